/* File: hw/ssl_pkg.sv */
// register map, field layout, reset values and tables of the link configuration block
`default_nettype none
package ssl_pkg;
	// register addresses, seven bits as carried in the first serial byte
	localparam int         ADDR_W          = 7;
	localparam logic [6:0] ADDR_OP_MODE    = 7'h01;
	localparam logic [6:0] ADDR_CONFIG1    = 7'h1d;
	localparam logic [6:0] ADDR_CONFIG2    = 7'h1e;
	localparam logic [6:0] ADDR_PRE_MSB    = 7'h20;
	localparam logic [6:0] ADDR_PRE_LSB    = 7'h21;
	localparam logic [6:0] ADDR_PAY_LEN    = 7'h22;
	localparam logic [6:0] ADDR_CONFIG3    = 7'h26;
	localparam logic [6:0] ADDR_DET_OPT    = 7'h31;
	localparam logic [6:0] ADDR_DET_THR    = 7'h37;

	// field positions
	localparam int OPM_LONG_RANGE  = 7;
	localparam int CFG1_BW_LSB     = 4;
	localparam int CFG1_CR_LSB     = 1;
	localparam int CFG1_HEADERLESS = 0;
	localparam int CFG2_SF_LSB     = 4;
	localparam int CFG2_CRC_ON     = 2;
	localparam int CFG3_SLOW_SYM   = 3;

	// device mode codes in the low three bits of the operating mode
	localparam logic [2:0] MODE_SLEEP   = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;

	// legal field ranges
	localparam logic [3:0] SF_MIN       = 4'h6;
	localparam logic [3:0] SF_MAX       = 4'hc;
	localparam logic [2:0] CR_MIN       = 3'h1;
	localparam logic [2:0] CR_MAX       = 3'h4;
	localparam logic [3:0] BW_CODE_MAX  = 4'h9;
	localparam logic [3:0] CR_BASE      = 4'h4;
	localparam logic [3:0] HDR_CR_DENOM = 4'h8;
	localparam logic [15:0] PRE_MIN     = 16'h0006;
	localparam logic [16:0] PRE_OVERHEAD = 17'h00004;

	// reset values
	localparam logic [3:0]  RST_BW_CODE  = 4'h7;
	localparam logic [2:0]  RST_CR       = 3'h1;
	localparam logic [3:0]  RST_SF       = 4'h7;
	localparam logic [15:0] RST_PREAMBLE = 16'h000c;
	localparam logic [7:0]  RST_PAY_LEN  = 8'h01;

	// double-sideband channel width in hertz for each bandwidth code, code 0 rightmost
	localparam int BW_W = 19;
	localparam logic [9:0][18:0] BW_HZ_TABLE = {
		19'h7a120, 19'h3d090, 19'h1e848, 19'h0f424, 19'h0a2e4,
		19'h079e0, 19'h05140, 19'h03cf0, 19'h028a0, 19'h01e78};

	// serial access phase
	typedef enum logic {
		SSL_SPI_ADDR = 1'b0,
		SSL_SPI_DATA = 1'b1
	} ssl_spi_e;
endpackage

`default_nettype wire

/* File: hw/ssl_link_config.sv */
// serial-accessed configuration and framing parameters of the spread-spectrum modem
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - modem switch only taken while in sleep
// - spread factor 6..12 gives 2^sf chips
// - code rate 1..4 gives 4/5..4/8
// - code rate may travel in header
// - ten bandwidths, 7.8 to 500 kHz
// - symbol rate is bandwidth over 2^sf
// - bandwidth means full double-sideband width
// - preamble length resets to twelve symbols
// - preamble 6..65535, sent four symbols longer
// - one bit picks headerless or header format
// - header: byte count, code rate, crc flag
// - header sent at 4/8 with own crc
module ssl_link_config #(
	parameter logic [7:0] DET_OPT_RESET = 8'h00,
	parameter logic [7:0] DET_THR_RESET = 8'h00
) (
	input  wire logic                    CLK,
	input  wire logic                    RESET,
	input  wire logic                    SCK,
	input  wire logic                    MOSI,
	input  wire logic                    NSS_N,
	output logic                         MISO,
	output logic                         MISO_OE_N,
	output logic                         LONG_RANGE_MODE,
	output logic [2:0]                   DEVICE_MODE,
	output logic [12:0]                  CHIPS_PER_SYMBOL,
	output logic [3:0]                   CODE_RATE_DENOM,
	output logic [ssl_pkg::BW_W-1:0]     BANDWIDTH_HZ,
	output logic [ssl_pkg::BW_W-1:0]     SYMBOL_RATE_HZ,
	output logic                         HEADER_PRESENT,
	output logic [3:0]                   HEADER_CODE_DENOM,
	output logic [11:0]                  HEADER_FIELDS,
	output logic [16:0]                  TX_PREAMBLE_SYMBOLS,
	output logic                         SLOW_SYMBOL_ROBUST,
	output logic [7:0]                   DETECT_OPTIMIZE,
	output logic [7:0]                   DETECT_THRESHOLD
);
	import ssl_pkg::*;

	logic                sck_s1, sck_s2, sck_s3;
	logic                nss_s1, nss_s2;
	logic                mosi_s1, mosi_s2;
	logic                sck_rise, sck_fall;
	ssl_spi_e            phase;
	logic [2:0]          bit_cnt;
	logic [6:0]          shift_in;
	logic                is_write;
	logic [ADDR_W-1:0]   reg_addr;
	logic [ADDR_W-1:0]   rd_addr;
	logic [7:0]          rd_data;
	logic [7:0]          miso_sr;
	logic                wr_en;
	logic [ADDR_W-1:0]   wr_addr;
	logic [7:0]          wr_data;
	logic                long_range;
	logic [2:0]          dev_mode;
	logic [3:0]          bw_code;
	logic [2:0]          code_rate;
	logic                headerless_select;
	logic [3:0]          spread_factor;
	logic                crc_on;
	logic                slow_symbol_robustness;
	logic [15:0]         preamble_symbol_count;
	logic [7:0]          payload_len;
	logic [7:0]          detection_optimize_ctrl;
	logic [7:0]          detection_threshold_ctrl;
	logic [15:0]         pre_eff;
	logic                wr_cfg1, wr_cfg2;

	// pins come from the host's clock, two stages before anything looks at them
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sck_s1  <= 1'b0;
			sck_s2  <= 1'b0;
			sck_s3  <= 1'b0;
			nss_s1  <= 1'b1;
			nss_s2  <= 1'b1;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
		end else begin
			sck_s1  <= SCK;
			sck_s2  <= sck_s1;
			sck_s3  <= sck_s2;
			nss_s1  <= NSS_N;
			nss_s2  <= nss_s1;
			mosi_s1 <= MOSI;
			mosi_s2 <= mosi_s1;
		end
	end

	// edges come from the settled stages only
	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;

	// read address: the one just received, or the next one of a burst
	always_comb begin
		rd_addr = (phase == SSL_SPI_ADDR) ? {shift_in[5:0], mosi_s2} : reg_addr + 7'h01;
	end

	// serial frame: address byte with write flag on top, then data bytes with auto-increment
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			phase    <= SSL_SPI_ADDR;
			bit_cnt  <= 3'h0;
			shift_in <= 7'h00;
			is_write <= 1'b0;
			reg_addr <= 7'h00;
			miso_sr  <= 8'h00;
			wr_en    <= 1'b0;
			wr_addr  <= 7'h00;
			wr_data  <= 8'h00;
		end else begin
			wr_en <= 1'b0;
			if (nss_s2) begin
				phase   <= SSL_SPI_ADDR;
				bit_cnt <= 3'h0;
			end else if (sck_rise) begin
				bit_cnt  <= bit_cnt + 3'h1;
				shift_in <= {shift_in[5:0], mosi_s2};
				if (bit_cnt == 3'h7) begin
					miso_sr <= rd_data;
					case (phase)
						SSL_SPI_ADDR: begin
							is_write <= shift_in[6];
							reg_addr <= {shift_in[5:0], mosi_s2};
							phase    <= SSL_SPI_DATA;
						end
						SSL_SPI_DATA: begin
							wr_en    <= is_write;
							wr_addr  <= reg_addr;
							wr_data  <= {shift_in, mosi_s2};
							reg_addr <= reg_addr + 7'h01;
						end
						default: phase <= SSL_SPI_ADDR;
					endcase
				end
			end else if (sck_fall && bit_cnt != 3'h0) begin
				// no shift on the fall right after a load, so bit 7 is not lost
				miso_sr <= {miso_sr[6:0], 1'b0};
			end
		end
	end

	// output driven only while selected
	assign MISO      = miso_sr[7];
	assign MISO_OE_N = nss_s2;

	// modem select may change only while asleep; the mode field always
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			long_range <= 1'b0;
			dev_mode   <= MODE_STANDBY;
		end else if (wr_en && wr_addr == ADDR_OP_MODE) begin
			dev_mode <= wr_data[2:0];
			if (dev_mode == MODE_SLEEP) begin
				long_range <= wr_data[OPM_LONG_RANGE];
			end
		end
	end

	assign wr_cfg1 = wr_en && wr_addr == ADDR_CONFIG1;
	assign wr_cfg2 = wr_en && wr_addr == ADDR_CONFIG2;

	// out-of-range codes are dropped per field so the modem never sees them
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			bw_code           <= RST_BW_CODE;
			code_rate         <= RST_CR;
			headerless_select <= 1'b0;
		end else if (wr_cfg1) begin
			if (wr_data[CFG1_BW_LSB +: 4] <= BW_CODE_MAX) begin
				bw_code <= wr_data[CFG1_BW_LSB +: 4];
			end
			if (wr_data[CFG1_CR_LSB +: 3] >= CR_MIN && wr_data[CFG1_CR_LSB +: 3] <= CR_MAX) begin
				code_rate <= wr_data[CFG1_CR_LSB +: 3];
			end
			headerless_select <= wr_data[CFG1_HEADERLESS];
		end
	end

	// spread factor and payload crc flag
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			spread_factor <= RST_SF;
			crc_on        <= 1'b0;
		end else if (wr_cfg2) begin
			if (wr_data[CFG2_SF_LSB +: 4] >= SF_MIN && wr_data[CFG2_SF_LSB +: 4] <= SF_MAX) begin
				spread_factor <= wr_data[CFG2_SF_LSB +: 4];
			end
			crc_on <= wr_data[CFG2_CRC_ON];
		end
	end

	// preamble length, payload length and slow-symbol bit
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			preamble_symbol_count  <= RST_PREAMBLE;
			payload_len            <= RST_PAY_LEN;
			slow_symbol_robustness <= 1'b0;
		end else if (wr_en) begin
			if (wr_addr == ADDR_PRE_MSB) begin
				preamble_symbol_count[15:8] <= wr_data;
			end
			if (wr_addr == ADDR_PRE_LSB) begin
				preamble_symbol_count[7:0] <= wr_data;
			end
			if (wr_addr == ADDR_PAY_LEN) begin
				payload_len <= wr_data;
			end
			if (wr_addr == ADDR_CONFIG3) begin
				slow_symbol_robustness <= wr_data[CFG3_SLOW_SYM];
			end
		end
	end

	// tuning registers the host sets for the smallest spread factor
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			detection_optimize_ctrl  <= DET_OPT_RESET;
			detection_threshold_ctrl <= DET_THR_RESET;
		end else if (wr_en) begin
			if (wr_addr == ADDR_DET_OPT) begin
				detection_optimize_ctrl <= wr_data;
			end
			if (wr_addr == ADDR_DET_THR) begin
				detection_threshold_ctrl <= wr_data;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (rd_addr)
			ADDR_OP_MODE: rd_data = {long_range, 4'h0, dev_mode};
			ADDR_CONFIG1: rd_data = {bw_code, code_rate, headerless_select};
			ADDR_CONFIG2: rd_data = {spread_factor, 1'b0, crc_on, 2'h0};
			ADDR_PRE_MSB: rd_data = preamble_symbol_count[15:8];
			ADDR_PRE_LSB: rd_data = preamble_symbol_count[7:0];
			ADDR_PAY_LEN: rd_data = payload_len;
			ADDR_CONFIG3: rd_data = {4'h0, slow_symbol_robustness, 3'h0};
			ADDR_DET_OPT: rd_data = detection_optimize_ctrl;
			ADDR_DET_THR: rd_data = detection_threshold_ctrl;
			default:      rd_data = 8'h00;
		endcase
	end

	// values below the floor act as the floor, so a short preamble cannot be sent
	assign pre_eff = (preamble_symbol_count < PRE_MIN) ? PRE_MIN : preamble_symbol_count;

	// derived link parameters, registered so the modem sees clean values
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			LONG_RANGE_MODE     <= 1'b0;
			DEVICE_MODE         <= MODE_STANDBY;
			CHIPS_PER_SYMBOL    <= 13'h0000;
			CODE_RATE_DENOM     <= 4'h0;
			BANDWIDTH_HZ        <= 19'h00000;
			SYMBOL_RATE_HZ      <= 19'h00000;
			HEADER_PRESENT      <= 1'b0;
			HEADER_CODE_DENOM   <= 4'h0;
			HEADER_FIELDS       <= 12'h000;
			TX_PREAMBLE_SYMBOLS <= 17'h00000;
			SLOW_SYMBOL_ROBUST  <= 1'b0;
			DETECT_OPTIMIZE     <= 8'h00;
			DETECT_THRESHOLD    <= 8'h00;
		end else begin
			LONG_RANGE_MODE     <= long_range;
			DEVICE_MODE         <= dev_mode;
			CHIPS_PER_SYMBOL    <= 13'h0001 << spread_factor;
			CODE_RATE_DENOM     <= CR_BASE + {1'b0, code_rate};
			BANDWIDTH_HZ        <= BW_HZ_TABLE[bw_code];
			SYMBOL_RATE_HZ      <= BW_HZ_TABLE[bw_code] >> spread_factor;
			HEADER_PRESENT      <= ~headerless_select;
			// header always at the strongest code; its crc is added by the framer
			HEADER_CODE_DENOM   <= headerless_select ? 4'h0 : HDR_CR_DENOM;
			HEADER_FIELDS       <= {payload_len, code_rate, crc_on};
			TX_PREAMBLE_SYMBOLS <= {1'b0, pre_eff} + PRE_OVERHEAD;
			SLOW_SYMBOL_ROBUST  <= slow_symbol_robustness;
			DETECT_OPTIMIZE     <= detection_optimize_ctrl;
			DETECT_THRESHOLD    <= detection_threshold_ctrl;
		end
	end
endmodule // ssl_link_config

`default_nettype wire

/* File: bench/ssl_link_config_chk.sv */
// concurrent checks on the configuration outputs of the link block
`timescale 1ns/1ps
`default_nettype none
module ssl_link_config_chk (
	input wire logic                     CLK,
	input wire logic                     RESET,
	input wire logic                     NSS_N,
	input wire logic                     MISO_OE_N,
	input wire logic                     LONG_RANGE_MODE,
	input wire logic [2:0]               DEVICE_MODE,
	input wire logic [12:0]              CHIPS_PER_SYMBOL,
	input wire logic [3:0]               CODE_RATE_DENOM,
	input wire logic [ssl_pkg::BW_W-1:0] BANDWIDTH_HZ,
	input wire logic [ssl_pkg::BW_W-1:0] SYMBOL_RATE_HZ,
	input wire logic                     HEADER_PRESENT,
	input wire logic [3:0]               HEADER_CODE_DENOM,
	input wire logic [11:0]              HEADER_FIELDS,
	input wire logic [16:0]              TX_PREAMBLE_SYMBOLS
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	logic up;
	// outputs hold zeros for one edge after reset, so checks wait for this flag
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) up <= 1'b0;
		else up <= 1'b1;
	end
	property p_chips; up |-> CHIPS_PER_SYMBOL inside {13'h40, 13'h80, 13'h100,
		13'h200, 13'h400, 13'h800, 13'h1000}; endproperty
	a_chips: assert property (p_chips) else $error("chip count off");
	property p_rate; up |-> SYMBOL_RATE_HZ == BANDWIDTH_HZ / CHIPS_PER_SYMBOL; endproperty
	a_rate: assert property (p_rate) else $error("symbol rate off");
	property p_denom; up |-> CODE_RATE_DENOM == HEADER_FIELDS[3:1] + 4'h4; endproperty
	a_denom: assert property (p_denom) else $error("code rate off");
	property p_bw; up |-> BANDWIDTH_HZ inside {19'h01e78, 19'h028a0, 19'h03cf0, 19'h05140,
		19'h079e0, 19'h0a2e4, 19'h0f424, 19'h1e848, 19'h3d090, 19'h7a120}; endproperty
	a_bw: assert property (p_bw) else $error("bandwidth off");
	property p_hdr; up |-> HEADER_CODE_DENOM == (HEADER_PRESENT ? 4'h8 : 4'h0); endproperty
	a_hdr: assert property (p_hdr) else $error("header rate off");
	property p_pre; up |-> TX_PREAMBLE_SYMBOLS >= 17'h0000a; endproperty
	a_pre: assert property (p_pre) else $error("preamble short");
	property p_lrm; up && $changed(LONG_RANGE_MODE) |-> $past(DEVICE_MODE) == 3'h0; endproperty
	a_lrm: assert property (p_lrm) else $error("modem switched awake");
	property p_oe; $rose(NSS_N) |-> ##[1:4] MISO_OE_N; endproperty
	a_oe: assert property (p_oe) else $error("output not released");
	property p_oe_low; $fell(NSS_N) |-> ##[1:4] !MISO_OE_N; endproperty
	a_oe_low: assert property (p_oe_low) else $error("output not driven");
endmodule // ssl_link_config_chk

bind ssl_link_config ssl_link_config_chk u_chk (.CLK(CLK), .RESET(RESET), .NSS_N(NSS_N),
	.MISO_OE_N(MISO_OE_N), .LONG_RANGE_MODE(LONG_RANGE_MODE), .DEVICE_MODE(DEVICE_MODE),
	.CHIPS_PER_SYMBOL(CHIPS_PER_SYMBOL), .CODE_RATE_DENOM(CODE_RATE_DENOM),
	.BANDWIDTH_HZ(BANDWIDTH_HZ), .SYMBOL_RATE_HZ(SYMBOL_RATE_HZ),
	.HEADER_PRESENT(HEADER_PRESENT), .HEADER_CODE_DENOM(HEADER_CODE_DENOM),
	.HEADER_FIELDS(HEADER_FIELDS), .TX_PREAMBLE_SYMBOLS(TX_PREAMBLE_SYMBOLS));
`default_nettype wire

/* File: bench/ssl_peer_model.sv */
// peer transceiver: holds its own link settings and says whether ours can talk to it
`timescale 1ns/1ps
`default_nettype none
module ssl_peer_model #(
	parameter logic [12:0] PEER_CHIPS    = 13'h1000,
	parameter logic [16:0] PEER_PREAMBLE = 17'h0000b,
	parameter logic        PEER_SLOW     = 1'b1
) (
	input wire logic        clk,
	input wire logic [12:0] chips,
	input wire logic [16:0] preamble,
	input wire logic        slow,
	output logic            link_ok
);
	// other spread factors are orthogonal, so any mismatch loses the link
	always_ff @(posedge clk) begin
		link_ok <= (chips == PEER_CHIPS)
			&& (preamble == PEER_PREAMBLE)
			&& (slow == PEER_SLOW);
	end
endmodule // ssl_peer_model
`default_nettype wire

/* File: bench/tb_ssl_link_config.sv */
// self-checking bench for the link configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_ssl_link_config;
	import ssl_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sck = 1'b0;
	logic        mosi = 1'b0;
	logic        nss_n = 1'b1;
	logic        miso, oe_n, lrm, hdr_p, slow, ok;
	logic [2:0]  mode;
	logic [12:0] chips;
	logic [3:0]  cr_d, hdr_d;
	logic [18:0] bw, sr;
	logic [11:0] hf;
	logic [16:0] pre;
	logic [7:0]  dopt, dthr;
	logic [2:0]  cr;
	int          fails = 0;
	int          comparisons = 0;
	logic [18:0] bw_tab [10] = '{19'h01e78, 19'h028a0, 19'h03cf0, 19'h05140, 19'h079e0,
		19'h0a2e4, 19'h0f424, 19'h1e848, 19'h3d090, 19'h7a120};

	// 50 MHz clock
	always #10 clk = ~clk;

	ssl_link_config dut (.CLK(clk), .RESET(rst), .SCK(sck), .MOSI(mosi), .NSS_N(nss_n),
		.MISO(miso), .MISO_OE_N(oe_n), .LONG_RANGE_MODE(lrm), .DEVICE_MODE(mode),
		.CHIPS_PER_SYMBOL(chips), .CODE_RATE_DENOM(cr_d), .BANDWIDTH_HZ(bw),
		.SYMBOL_RATE_HZ(sr), .HEADER_PRESENT(hdr_p), .HEADER_CODE_DENOM(hdr_d),
		.HEADER_FIELDS(hf), .TX_PREAMBLE_SYMBOLS(pre), .SLOW_SYMBOL_ROBUST(slow),
		.DETECT_OPTIMIZE(dopt), .DETECT_THRESHOLD(dthr));
	ssl_peer_model peer (.clk(clk), .chips(chips), .preamble(pre), .slow(slow), .link_ok(ok));

	task report_and_stop;
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	// one frame: address byte then one data byte; sck held high for 4 clocks and low for 6
	task xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {w, a, d};
		q = 8'h00;
		nss_n <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 15; i >= 0; i--) begin
			mosi <= f[i];
			repeat (3) @(posedge clk);
			if (i < 8) q[i] = miso;
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			sck <= 1'b0;
			repeat (3) @(posedge clk);
		end
		nss_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task rd_chk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(q, exp, "read");
	endtask

	// hang guard well above the longest sequence
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		report_and_stop;
	end

	// main sequence; 868 MHz band assumed, so all ten bandwidths are legal
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk(mode, MODE_STANDBY, "mode");
		chk(pre, 17'h00010, "pre");
		chk(chips, 13'h0080, "chips");
		chk(sr, 19'h003d0, "rate");
		chk(hdr_p, 1'b1, "hdr");
		rd_chk(ADDR_DET_OPT, 8'h00);
		wr(ADDR_DET_OPT, 8'h05);
		wr(ADDR_DET_THR, 8'h0c);
		rd_chk(ADDR_DET_OPT, 8'h05);
		rd_chk(ADDR_DET_THR, 8'h0c);
		chk(dopt, 8'h05, "opt");
		chk(dthr, 8'h0c, "thr");
		rd_chk(7'h7f, 8'h00);
		wr(ADDR_CONFIG1, 8'h71);
		chk(hdr_p, 1'b0, "hdr");
		chk(hdr_d, 4'h0, "hdr rate");
		for (logic [3:0] s = 4'h6; s <= 4'hc; s++) begin
			wr(ADDR_CONFIG2, {s, 4'h0});
			chk(chips, 13'h0001 << s, "chips");
			chk(sr, 19'h1e848 >> s, "rate");
		end
		wr(ADDR_CONFIG2, 8'hd0);
		chk(chips, 13'h1000, "sf 13");
		for (int b = 0; b < 10; b++) begin
			cr = 3'(b % 4 + 1);
			wr(ADDR_CONFIG1, {b[3:0], cr, 1'b0});
			chk(bw, bw_tab[b], "bw");
			chk(sr, bw_tab[b] >> 12, "rate");
			chk(cr_d, 4'h4 + cr, "cr");
			chk(hf, {8'h01, cr, 1'b0}, "fields");
			chk(hdr_d, 4'h8, "hdr rate");
		end
		wr(ADDR_CONFIG1, 8'ha6);
		chk(bw, 19'h7a120, "bw 10");
		chk(cr_d, 4'h7, "cr");
		wr(ADDR_CONFIG1, 8'h9a);
		chk(hf[3:1], 3'h3, "cr 5");
		wr(ADDR_PRE_MSB, 8'hff);
		wr(ADDR_PRE_LSB, 8'hff);
		chk(pre, 17'h10003, "pre max");
		wr(ADDR_PRE_MSB, 8'h00);
		wr(ADDR_PRE_LSB, 8'h03);
		chk(pre, 17'h0000a, "pre min");
		wr(ADDR_PRE_LSB, 8'h07);
		wr(ADDR_OP_MODE, 8'h81);
		chk(lrm, 1'b0, "awake switch");
		wr(ADDR_OP_MODE, 8'h00);
		wr(ADDR_OP_MODE, 8'h80);
		chk(lrm, 1'b1, "sleep switch");
		chk(mode, 3'h0, "sleep mode");
		rd_chk(ADDR_OP_MODE, 8'h80);
		wr(ADDR_CONFIG3, 8'h08);
		chk(slow, 1'b1, "slow");
		wr(ADDR_PAY_LEN, 8'h2a);
		wr(ADDR_CONFIG2, 8'hc4);
		chk(hf, {8'h2a, 3'h3, 1'b1}, "fields crc");
		rd_chk(ADDR_CONFIG2, 8'hc4);
		chk(ok, 1'b1, "peer link");
		report_and_stop;
	end
endmodule // tb_ssl_link_config
`default_nettype wire
